// File: ppc_pkg.sv
// Package with register layouts, reset values and codes for the pin decoder.
package ppc_pkg;

   // ---------------------------------------------------------------
   // Register indices of the pin-driven register image
   // ---------------------------------------------------------------
   localparam logic [2:0] REG_HS_MODES = 3'h0;
   localparam logic [2:0] REG_AUX_MODES = 3'h1;
   localparam logic [2:0] REG_RX_SETTINGS = 3'h2;
   localparam logic [2:0] REG_TERM_PULSE_AB = 3'h3;
   localparam logic [2:0] REG_TERM_PULSE_CD = 3'h4;
   localparam logic [2:0] REG_RX_EQ_AB = 3'h5;
   localparam logic [2:0] REG_RX_EQ_CD = 3'h6;
   localparam logic [2:0] REG_TX_SETTINGS = 3'h7;
   localparam int NUM_REGS = 8;

   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int MODES_ENABLE_BIT = 6;
   localparam int MODES_MODE_LSB = 4;
   localparam int MODES_SRC_LSB = 0;
   localparam int RX_TERM_BIT = 0;
   localparam int TX_PE_LSB = 3;
   localparam int TX_OTO_BIT = 1;
   localparam int OUTPUT_CURRENT_FIELD_BIT = 0;

   // ---------------------------------------------------------------
   // Fixed codes and reset values
   // ---------------------------------------------------------------
   localparam logic [1:0] MODE_QUAD = 2'h0;
   localparam logic [7:0] TERM_PULSE_OFF = 8'h00;
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [7:0] HS_MODES_RESET = 8'h00;
   localparam logic [7:0] AUX_MODES_RESET = 8'h40;
   localparam logic [7:0] RX_SETTINGS_RESET = 8'h01;

   typedef enum logic [1:0] {
      PPC_SRC_A, PPC_SRC_B, PPC_SRC_C, PPC_SRC_D
   } ppc_src_e;

   typedef enum logic [1:0] {
      PPC_PE_NONE, PPC_PE_LOW, PPC_PE_MED, PPC_PE_HIGH
   } ppc_pe_e;

endpackage

// File: ppc_sync.sv
// Two-flop synchroniser for a bus of strap pins.
`timescale 1ns/1ps
module ppc_sync
   import ppc_pkg::*;
#(
   parameter int WIDTH = 8
) (
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Data
   input wire logic [WIDTH-1:0] din,
   output logic [WIDTH-1:0] dout
);

   logic [WIDTH-1:0] stage1;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         stage1 <= '0;
         dout <= '0;
      end else begin
         stage1 <= din;
         dout <= stage1;
      end
   end

endmodule

// File: ppc_onehot.sv
// Two-bit code to four-way one-hot select decoder.
`timescale 1ns/1ps
module ppc_onehot
   import ppc_pkg::*;
(
   // Code in
   input wire logic [1:0] code,
   // One-hot out
   output logic [3:0] onehot
);

   genvar i;
   generate
      for (i = 0; i < 4; i++) begin : g_dec
         assign onehot[i] = (code == 2'(i));
      end
   endgenerate

endmodule

// File: ppc_parallel_pin_config_decoder.sv
// Strap-pin decoder that builds the register image and drive settings.
`timescale 1ns/1ps
module ppc_parallel_pin_config_decoder
   import ppc_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Strap pins
   input wire logic hs_channel_enable_pin,
   input wire logic [1:0] source_select_pins,
   input wire logic equalization_level_pin,
   input wire logic [1:0] preemphasis_level_pins,
   input wire logic output_termination_pin,
   input wire logic output_current_pin,
   // Serial interface takeover
   input wire logic serial_access,
   input wire logic [2:0] serial_addr,
   input wire logic [7:0] serial_wdata,
   input wire logic serial_write,
   // Register image read port
   input wire logic [2:0] read_addr,
   output logic [7:0] read_data,
   // Register image
   output logic [7:0] high_speed_switch_modes,
   output logic [7:0] auxiliary_switch_modes,
   output logic [7:0] receiver_settings,
   output logic [7:0] input_termination_pulse_ab,
   output logic [7:0] input_termination_pulse_cd,
   output logic [7:0] receive_equalizer_ab,
   output logic [7:0] receive_equalizer_cd,
   output logic [7:0] transmitter_settings,
   // Decoded drive settings
   output logic hs_channels_on,
   output logic [3:0] hs_source_onehot,
   output logic [3:0] aux_source_onehot,
   output logic equalization_high,
   output logic [1:0] preemphasis_level,
   output logic output_termination_on,
   output logic output_current_high,
   output logic parallel_active
);

   // ---------------------------------------------------------------
   // Pin synchronisation
   // ---------------------------------------------------------------
   logic [7:0] pins_raw;
   logic [7:0] pins;
   logic [3:0] next_src_onehot;

   assign pins_raw = {hs_channel_enable_pin, source_select_pins,
      equalization_level_pin, preemphasis_level_pins,
      output_termination_pin, output_current_pin};

   ppc_sync #(.WIDTH(8)) u_sync (
      .clk(clk),
      .nrst(nrst),
      .din(pins_raw),
      .dout(pins)
   );

   logic pin_en;
   logic [1:0] pin_src;
   logic pin_eq;
   logic [1:0] pin_pe;
   logic pin_oto;
   logic pin_ocl;

   assign pin_en = pins[7];
   assign pin_src = pins[6:5];
   assign pin_eq = pins[4];
   assign pin_pe = pins[3:2];
   assign pin_oto = pins[1];
   assign pin_ocl = pins[0];

   ppc_onehot u_dec (
      .code(pin_src),
      .onehot(next_src_onehot)
   );

   // ---------------------------------------------------------------
   // Serial source decode
   // ---------------------------------------------------------------
   logic [3:0] wr_src_onehot;

   ppc_onehot u_wr_dec (
      .code(serial_wdata[MODES_SRC_LSB +: 2]),
      .onehot(wr_src_onehot)
   );

   // ---------------------------------------------------------------
   // Ownership: pins until first serial access
   // ---------------------------------------------------------------
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         parallel_active <= 1'b1;
      end else if (serial_access) begin
         parallel_active <= 1'b0;
      end
   end

   logic take_pins;
   assign take_pins = parallel_active && !serial_access;

   // ---------------------------------------------------------------
   // Serial write select
   // ---------------------------------------------------------------
   logic [NUM_REGS-1:0] wr_sel;

   always_comb begin
      wr_sel = '0;
      if (!serial_write || take_pins) begin
         wr_sel = '0;
      end else if (serial_addr == REG_HS_MODES) begin
         wr_sel[REG_HS_MODES] = 1'b1;
      end else if (serial_addr == REG_AUX_MODES) begin
         wr_sel[REG_AUX_MODES] = 1'b1;
      end else if (serial_addr == REG_RX_SETTINGS) begin
         wr_sel[REG_RX_SETTINGS] = 1'b1;
      end else if (serial_addr == REG_TERM_PULSE_AB) begin
         wr_sel[REG_TERM_PULSE_AB] = 1'b1;
      end else if (serial_addr == REG_TERM_PULSE_CD) begin
         wr_sel[REG_TERM_PULSE_CD] = 1'b1;
      end else if (serial_addr == REG_RX_EQ_AB) begin
         wr_sel[REG_RX_EQ_AB] = 1'b1;
      end else if (serial_addr == REG_RX_EQ_CD) begin
         wr_sel[REG_RX_EQ_CD] = 1'b1;
      end else begin
         wr_sel[REG_TX_SETTINGS] = 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // Register image
   // ---------------------------------------------------------------
   logic [7:0] next_hs;
   logic [7:0] next_aux;
   logic [7:0] next_tx;
   logic [7:0] next_eq;

   always_comb begin
      next_hs = 8'h00;
      next_hs[MODES_ENABLE_BIT] = pin_en;
      next_hs[MODES_MODE_LSB +: 2] = MODE_QUAD;
      next_hs[MODES_SRC_LSB +: 2] = pin_src;
      next_aux = 8'h00;
      next_aux[MODES_ENABLE_BIT] = 1'b1;
      next_aux[MODES_MODE_LSB +: 2] = MODE_QUAD;
      next_aux[MODES_SRC_LSB +: 2] = pin_src;
      next_tx = 8'h00;
      next_tx[TX_PE_LSB -: 2] = pin_pe;
      next_tx[TX_OTO_BIT] = pin_oto;
      next_tx[OUTPUT_CURRENT_FIELD_BIT] = pin_ocl;
      next_eq = {8{pin_eq}};
   end

   // Each register is reloaded every cycle while the pins govern; the receiver and pulse registers take fixed values.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         high_speed_switch_modes <= HS_MODES_RESET;
      end else if (take_pins) begin
         high_speed_switch_modes <= next_hs;
      end else if (wr_sel[REG_HS_MODES]) begin
         high_speed_switch_modes <= serial_wdata;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         auxiliary_switch_modes <= AUX_MODES_RESET;
      end else if (take_pins) begin
         auxiliary_switch_modes <= next_aux;
      end else if (wr_sel[REG_AUX_MODES]) begin
         auxiliary_switch_modes <= serial_wdata;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         receiver_settings <= RX_SETTINGS_RESET;
      end else if (take_pins) begin
         receiver_settings <= RX_SETTINGS_RESET;
      end else if (wr_sel[REG_RX_SETTINGS]) begin
         receiver_settings <= serial_wdata;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         input_termination_pulse_ab <= TERM_PULSE_OFF;
      end else if (take_pins) begin
         input_termination_pulse_ab <= TERM_PULSE_OFF;
      end else if (wr_sel[REG_TERM_PULSE_AB]) begin
         input_termination_pulse_ab <= serial_wdata;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         input_termination_pulse_cd <= TERM_PULSE_OFF;
      end else if (take_pins) begin
         input_termination_pulse_cd <= TERM_PULSE_OFF;
      end else if (wr_sel[REG_TERM_PULSE_CD]) begin
         input_termination_pulse_cd <= serial_wdata;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         receive_equalizer_ab <= REG_RESET;
      end else if (take_pins) begin
         receive_equalizer_ab <= next_eq;
      end else if (wr_sel[REG_RX_EQ_AB]) begin
         receive_equalizer_ab <= serial_wdata;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         receive_equalizer_cd <= REG_RESET;
      end else if (take_pins) begin
         receive_equalizer_cd <= next_eq;
      end else if (wr_sel[REG_RX_EQ_CD]) begin
         receive_equalizer_cd <= serial_wdata;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         transmitter_settings <= REG_RESET;
      end else if (take_pins) begin
         transmitter_settings <= next_tx;
      end else if (wr_sel[REG_TX_SETTINGS]) begin
         transmitter_settings <= serial_wdata;
      end
   end

   // ---------------------------------------------------------------
   // Decoded drive settings
   // ---------------------------------------------------------------
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         hs_channels_on <= 1'b0;
      end else if (take_pins) begin
         hs_channels_on <= pin_en;
      end else if (wr_sel[REG_HS_MODES]) begin
         hs_channels_on <= serial_wdata[MODES_ENABLE_BIT];
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         hs_source_onehot <= 4'h1;
      end else if (take_pins) begin
         hs_source_onehot <= next_src_onehot;
      end else if (wr_sel[REG_HS_MODES]) begin
         hs_source_onehot <= wr_src_onehot;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         aux_source_onehot <= 4'h1;
      end else if (take_pins) begin
         aux_source_onehot <= next_src_onehot;
      end else if (wr_sel[REG_AUX_MODES]) begin
         aux_source_onehot <= wr_src_onehot;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         equalization_high <= 1'b0;
      end else if (take_pins) begin
         equalization_high <= pin_eq;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         preemphasis_level <= PPC_PE_NONE;
      end else if (take_pins) begin
         preemphasis_level <= pin_pe;
      end else if (wr_sel[REG_TX_SETTINGS]) begin
         preemphasis_level <= serial_wdata[TX_PE_LSB -: 2];
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         output_termination_on <= 1'b0;
      end else if (take_pins) begin
         output_termination_on <= pin_oto;
      end else if (wr_sel[REG_TX_SETTINGS]) begin
         output_termination_on <= serial_wdata[TX_OTO_BIT];
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         output_current_high <= 1'b0;
      end else if (take_pins) begin
         output_current_high <= pin_ocl;
      end else if (wr_sel[REG_TX_SETTINGS]) begin
         output_current_high <= serial_wdata[OUTPUT_CURRENT_FIELD_BIT];
      end
   end

   // ---------------------------------------------------------------
   // Register image read port
   // ---------------------------------------------------------------
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         read_data <= 8'h00;
      end else if (read_addr == REG_HS_MODES) begin
         read_data <= high_speed_switch_modes;
      end else if (read_addr == REG_AUX_MODES) begin
         read_data <= auxiliary_switch_modes;
      end else if (read_addr == REG_RX_SETTINGS) begin
         read_data <= receiver_settings;
      end else if (read_addr == REG_TERM_PULSE_AB) begin
         read_data <= input_termination_pulse_ab;
      end else if (read_addr == REG_TERM_PULSE_CD) begin
         read_data <= input_termination_pulse_cd;
      end else if (read_addr == REG_RX_EQ_AB) begin
         read_data <= receive_equalizer_ab;
      end else if (read_addr == REG_RX_EQ_CD) begin
         read_data <= receive_equalizer_cd;
      end else begin
         read_data <= transmitter_settings;
      end
   end

endmodule

// File: ppc_strap_model.sv
// Board strap model that ties the configuration pins to fixed levels.
`timescale 1ns/1ps
module ppc_strap_model (
   // Requested strap levels
   input wire logic [7:0] straps,
   // Strap pins
   output logic hs_channel_enable_pin,
   output logic [1:0] source_select_pins,
   output logic equalization_level_pin,
   output logic [1:0] preemphasis_level_pins,
   output logic output_termination_pin,
   output logic output_current_pin
);
   // Straps are plain levels, so the pins follow the requested set directly.
   assign {hs_channel_enable_pin, source_select_pins, equalization_level_pin,
      preemphasis_level_pins, output_termination_pin,
      output_current_pin} = straps;
endmodule

// File: ppc_parallel_pin_config_decoder_asserts.sv
// Checker for the strap-pin configuration decoder.
`timescale 1ns/1ps
module ppc_asserts (
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Watched ports
   input wire logic serial_access,
   input wire logic parallel_active,
   input wire logic [7:0] high_speed_switch_modes,
   input wire logic [7:0] auxiliary_switch_modes,
   input wire logic [7:0] receiver_settings,
   input wire logic [7:0] input_termination_pulse_ab,
   input wire logic [7:0] input_termination_pulse_cd,
   input wire logic [7:0] receive_equalizer_ab,
   input wire logic [7:0] receive_equalizer_cd,
   input wire logic hs_channels_on,
   input wire logic [3:0] hs_source_onehot,
   input wire logic [3:0] aux_source_onehot,
   input wire logic equalization_high
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   sequence s_takeover;
      serial_access ##1 !parallel_active;
   endsequence
   sequence s_stay_serial;
      !parallel_active [*3];
   endsequence
   AST_HS_QUAD: assert property (parallel_active |->
      high_speed_switch_modes[5:4] == 2'h0) else $error("hs mode not quad");
   AST_HS_EN: assert property (hs_channels_on ==
      high_speed_switch_modes[6]) else $error("channel enable mismatch");
   AST_HS_SRC: assert property (hs_source_onehot ==
      (4'h1 << high_speed_switch_modes[1:0])) else $error("hs source bad");
   AST_AUX_FIXED: assert property (parallel_active |->
      auxiliary_switch_modes[7:2] == 6'h10) else $error("aux mode bad");
   AST_AUX_SRC: assert property (parallel_active |->
      aux_source_onehot == (4'h1 << auxiliary_switch_modes[1:0]) &&
      auxiliary_switch_modes[1:0] == high_speed_switch_modes[1:0])
      else $error("aux source bad");
   AST_RX_TERM: assert property (parallel_active |->
      receiver_settings == 8'h01) else $error("input termination off");
   AST_PULSE_OFF: assert property (parallel_active |->
      (input_termination_pulse_ab | input_termination_pulse_cd) == 8'h00)
      else $error("termination pulsing on");
   AST_EQ_ALL: assert property (parallel_active |->
      receive_equalizer_ab == {8{equalization_high}} &&
      receive_equalizer_cd == receive_equalizer_ab) else $error("eq bad");
   AST_TAKEOVER: assert property (serial_access |-> s_takeover ##1
      s_stay_serial) else $error("pin control not ended");
endmodule
bind ppc_parallel_pin_config_decoder ppc_asserts i_asserts (.clk, .nrst,
   .serial_access, .parallel_active, .high_speed_switch_modes,
   .auxiliary_switch_modes, .receiver_settings, .input_termination_pulse_ab,
   .input_termination_pulse_cd, .receive_equalizer_ab, .receive_equalizer_cd,
   .hs_channels_on, .hs_source_onehot, .aux_source_onehot,
   .equalization_high);

// File: ppc_parallel_pin_config_decoder_bench.sv
// Testbench for the strap-pin configuration decoder.
`timescale 1ns/1ps
module parallel_pin_config_decoder_bench;
   import ppc_pkg::*;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic [7:0] cfg = 8'h00;
   logic serial_access = 1'b0, serial_write = 1'b0;
   logic [2:0] serial_addr = 3'h0, read_addr = 3'h0;
   logic [7:0] serial_wdata = 8'h00;
   logic en, eq, oto, ocl, hs_on, eq_hi, oto_on, ocl_hi, pact;
   logic [1:0] src, pe, pe_lvl;
   logic [3:0] hs_oh, aux_oh;
   logic [7:0] rd, img [8];
   int num_errors = 0, cmp_count = 0;
   always #2.5 clk = ~clk;
   ppc_strap_model i_straps (.straps(cfg), .hs_channel_enable_pin(en),
      .source_select_pins(src), .equalization_level_pin(eq),
      .preemphasis_level_pins(pe), .output_termination_pin(oto),
      .output_current_pin(ocl));
   ppc_parallel_pin_config_decoder i_dut (.clk(clk), .nrst(nrst),
      .hs_channel_enable_pin(en), .source_select_pins(src),
      .equalization_level_pin(eq), .preemphasis_level_pins(pe),
      .output_termination_pin(oto), .output_current_pin(ocl),
      .serial_access(serial_access), .serial_addr(serial_addr),
      .serial_wdata(serial_wdata), .serial_write(serial_write),
      .read_addr(read_addr), .read_data(rd),
      .high_speed_switch_modes(img[0]), .auxiliary_switch_modes(img[1]),
      .receiver_settings(img[2]), .input_termination_pulse_ab(img[3]),
      .input_termination_pulse_cd(img[4]), .receive_equalizer_ab(img[5]),
      .receive_equalizer_cd(img[6]), .transmitter_settings(img[7]),
      .hs_channels_on(hs_on), .hs_source_onehot(hs_oh),
      .aux_source_onehot(aux_oh), .equalization_high(eq_hi),
      .preemphasis_level(pe_lvl), .output_termination_on(oto_on),
      .output_current_high(ocl_hi), .parallel_active(pact));
   task automatic chk(string what, logic [7:0] seen, logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   function automatic logic [7:0] exp_reg(input int a);
      case (a)
         0: exp_reg = {1'b0, cfg[7], 4'h0, cfg[6:5]};
         1: exp_reg = {6'h10, cfg[6:5]};
         2: exp_reg = 8'h01;
         5, 6: exp_reg = {8{cfg[4]}};
         7: exp_reg = {4'h0, cfg[3:0]};
         default: exp_reg = 8'h00;
      endcase
   endfunction
   task automatic set_straps(logic [7:0] v);
      @(posedge clk);
      cfg <= v;
      repeat (4) @(posedge clk);
      #1;
   endtask
   // Walks every source code and every level of each strap pin.
   task automatic t_straps();
      for (int i = 0; i < 4; i++) begin
         set_straps({i[1], i[1:0], i[0], i[1:0], i[1], ~i[0]});
         for (int a = 0; a < 8; a++) begin
            chk("image", img[a], exp_reg(a));
         end
         chk("hs_on", hs_on, i[1]);
         chk("hs_src", hs_oh, 8'h1 << i);
         chk("aux_src", aux_oh, 8'h1 << i);
         chk("eq_hi", eq_hi, i[0]);
         chk("pe", pe_lvl, i[1:0]);
         chk("oto", oto_on, i[1]);
         chk("ocl", ocl_hi, !i[0]);
      end
      $display("test straps done");
   endtask
   // Reads the whole image back through the read port.
   task automatic t_read();
      for (int a = 0; a < 8; a++) begin
         @(posedge clk);
         read_addr <= a[2:0];
         @(posedge clk);
         #1;
         chk("read_data", rd, exp_reg(a));
      end
      $display("test read done");
   endtask
   // Serial access ends pin control; a later reset gives it back.
   task automatic t_takeover();
      @(posedge clk);
      serial_access <= 1'b1;
      serial_write <= 1'b1;
      serial_addr <= REG_TX_SETTINGS;
      serial_wdata <= 8'h5a;
      @(posedge clk);
      serial_access <= 1'b0;
      serial_write <= 1'b0;
      for (int i = 0; i < 8 && pact !== 1'b0; i++) @(posedge clk);
      if (pact !== 1'b0) begin
         num_errors++;
         return;
      end
      chk("tx_first_write", img[7], 8'h5a);
      serial_write <= 1'b1;
      serial_wdata <= 8'ha5;
      @(posedge clk);
      serial_write <= 1'b0;
      set_straps(~cfg);
      chk("tx_serial", img[7], 8'ha5);
      chk("hs_frozen", img[0][6], !cfg[7]);
      chk("hs_on_frozen", hs_on, !cfg[7]);
      @(posedge clk);
      nrst <= 1'b0;
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      set_straps(cfg);
      chk("pact", pact, 8'h1);
      chk("tx_pins", img[7], exp_reg(7));
      $display("test takeover done");
   endtask
   // Every register takes serial writes once the serial side governs.
   task automatic t_serial_regs();
      logic [7:0] v;
      for (int a = 0; a < 8; a++) begin
         v = 8'h41 + 8'h11 * 8'(a);
         @(posedge clk);
         serial_access <= 1'b1;
         serial_write <= 1'b1;
         serial_addr <= a[2:0];
         serial_wdata <= v;
         read_addr <= a[2:0];
         @(posedge clk);
         serial_access <= 1'b0;
         serial_write <= 1'b0;
         @(posedge clk);
         #1;
         chk("serial_image", img[a], v);
         chk("serial_read", rd, v);
      end
      chk("hs_on_serial", hs_on, 8'h1);
      chk("hs_src_serial", hs_oh, 8'h2);
      chk("aux_src_serial", aux_oh, 8'h4);
      chk("pe_serial", pe_lvl, 8'h2);
      chk("oto_serial", oto_on, 8'h0);
      chk("ocl_serial", ocl_hi, 8'h0);
      chk("pact_serial", pact, 8'h0);
      $display("test serial registers done");
   endtask
   initial begin
      repeat (12) @(posedge clk);
      nrst <= 1'b1;
      t_straps();
      t_read();
      t_takeover();
      t_serial_regs();
      wrap_up();
   end
endmodule
